// ===== src/alt_pkg.sv
// Package with opcodes, widths and carriers for the accumulator load transfers.
package alt_pkg;
  localparam int OpWidth = 10;
  localparam int DataWidth = 4;
  // Second timer-control read opcode as printed; the others are parameters of the top.
  localparam logic [9:0] OpReadTimerCtrlTwo = 10'h24c;
  localparam logic [9:0] OpReadTimerCtrlOneDflt = 10'h248;
  localparam logic [9:0] OpReadTimerCtrlThreeDflt = 10'h24e;
  localparam logic [9:0] OpReadTimerCtrlFourDflt = 10'h24f;
  localparam logic [9:0] OpReadXPointerDflt = 10'h052;
  localparam logic [9:0] OpReadYPointerDflt = 10'h05e;
  localparam logic [3:0] AccReset = 4'h0;
  localparam logic [5:0] SrcNone = 6'h00;

  // Source selector, one-hot.
  typedef enum logic [5:0] {
    ALT_SRC_NONE = 6'h00,
    ALT_SRC_W1 = 6'h01,
    ALT_SRC_W2 = 6'h02,
    ALT_SRC_W3 = 6'h04,
    ALT_SRC_W4 = 6'h08,
    ALT_SRC_X = 6'h10,
    ALT_SRC_Y = 6'h20
  } alt_src_e;

  // Register values presented by the timer block and the pointer registers.
  typedef struct packed {
    logic [3:0] timerCtrlRegOne;
    logic [3:0] timerCtrlRegTwo;
    logic [3:0] timerCtrlRegThree;
    logic [3:0] timerCtrlRegFour;
    logic [3:0] xPointer;
    logic [3:0] yPointer;
  } alt_srcs_s;

  // Result of one executed instruction.
  typedef struct packed {
    logic loaded;
    logic skipNext;
    logic [5:0] srcSel;
  } alt_result_s;
endpackage

// ===== src/alt_load_transfers.sv
// Decoder and accumulator datapath for the accumulator load transfer instructions.
`timescale 1ns/1ns

// The decoder watches one instruction word per machine cycle. When the word is one of
// the six accumulator loads, the addressed nibble is copied into A at the edge that ends
// the cycle. Every other word is left to the rest of the CPU: A holds, and the carry flag
// takes whatever the arithmetic unit offers. There is no pipeline and no stall, so a load
// and the word after it may follow back to back with no bubble.

module alt_load_transfers #(
  parameter logic [9:0] OpReadTimerCtrlOne = alt_pkg::OpReadTimerCtrlOneDflt,
  parameter logic [9:0] OpReadTimerCtrlThree = alt_pkg::OpReadTimerCtrlThreeDflt,
  parameter logic [9:0] OpReadTimerCtrlFour = alt_pkg::OpReadTimerCtrlFourDflt,
  parameter logic [9:0] OpReadXPointer = alt_pkg::OpReadXPointerDflt,
  parameter logic [9:0] OpReadYPointer = alt_pkg::OpReadYPointerDflt
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Instruction fetch, one word per machine cycle.
  input wire logic instrValid,
  input wire logic [alt_pkg::OpWidth-1:0] instrWord,
  // Source registers and the incoming carry.
  input wire alt_pkg::alt_srcs_s srcRegs,
  input wire logic carryIn,
  // Accumulator, carry flag and per-instruction result.
  output logic [alt_pkg::DataWidth-1:0] accOut,
  output logic carryFlag,
  output alt_pkg::alt_result_s result
);
  import alt_pkg::*;

  // Accumulator, carry flag and result word, each with its next value.
  logic [3:0] acc_ff;
  logic [3:0] nxt_acc;
  logic carry_ff;
  logic nxt_carry;
  alt_result_s res_ff;
  alt_result_s nxt_res;
  // One-hot source chosen by the decoder in the current cycle.
  alt_src_e sel;

  // All six opcodes in selector order, so that one loop can compare every pair.
  localparam logic [9:0] OpTable [6] = '{OpReadTimerCtrlOne, OpReadTimerCtrlTwo,
    OpReadTimerCtrlThree, OpReadTimerCtrlFour, OpReadXPointer, OpReadYPointer};

  // Opcodes must be distinct, otherwise the priority chain below would silently hide
  // one source. The clash is refused at elaboration rather than found in the field,
  // which also covers every pair and not only the ones that look likely.
  for (genvar i = 0; i < 5; i++)
  begin : g_op_chk
    for (genvar j = i + 1; j < 6; j++)
    begin : g_op_pair
      if (OpTable[i] == OpTable[j])
      begin : g_clash
        $error("alt_load_transfers: two transfer opcodes are equal");
      end
    end
  end

  // Decode; only a valid word selects a source. The chain gives a fixed priority, but the
  // elaboration check above keeps the opcodes apart, so the order never decides a result.
  // A word that matches none of the six leaves the selector at none and the datapath idle.
  always_comb
  begin
    sel = ALT_SRC_NONE;
    if (!instrValid)
      sel = ALT_SRC_NONE;
    else if (instrWord == OpReadTimerCtrlOne)
      sel = ALT_SRC_W1;
    else if (instrWord == OpReadTimerCtrlTwo)
      sel = ALT_SRC_W2;
    else if (instrWord == OpReadTimerCtrlThree)
      sel = ALT_SRC_W3;
    else if (instrWord == OpReadTimerCtrlFour)
      sel = ALT_SRC_W4;
    else if (instrWord == OpReadXPointer)
      sel = ALT_SRC_X;
    else if (instrWord == OpReadYPointer)
      sel = ALT_SRC_Y;
  end

  // Next accumulator and flags; other opcodes belong elsewhere and hold A here.
  // The carry flag is only a copy here: a transfer keeps it, any other word takes the
  // value that the rest of the arithmetic unit offers on carryIn in that same cycle.
  always_comb
  begin
    nxt_acc = acc_ff;
    case (sel)
      ALT_SRC_W1: nxt_acc = srcRegs.timerCtrlRegOne;
      ALT_SRC_W2: nxt_acc = srcRegs.timerCtrlRegTwo;
      ALT_SRC_W3: nxt_acc = srcRegs.timerCtrlRegThree;
      ALT_SRC_W4: nxt_acc = srcRegs.timerCtrlRegFour;
      ALT_SRC_X: nxt_acc = srcRegs.xPointer;
      ALT_SRC_Y: nxt_acc = srcRegs.yPointer;
      default: nxt_acc = acc_ff;
    endcase
    nxt_carry = (sel == ALT_SRC_NONE) ? carryIn : carry_ff;
    // The result word is rebuilt every cycle, so it can never stand longer than one cycle.
    nxt_res.loaded = (sel != ALT_SRC_NONE);
    nxt_res.skipNext = 1'b0;
    nxt_res.srcSel = sel;
  end

  // Registers; the load completes at the edge that ends the cycle.
  // A synchronous reset keeps the whole block in one timing domain with no reset tree.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_ff <= AccReset;
      carry_ff <= 1'b0;
      res_ff <= '0;
    end
    else
    begin
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      res_ff <= nxt_res;
    end
  end

  // Every output is the flip-flop itself, so nothing combinational reaches the pins.
  assign accOut = acc_ff;
  assign carryFlag = carry_ff;
  assign result = res_ff;

  // The checks below sample at the rising edge and sleep through reset.
  // Each transfer must land the addressed nibble in A one edge after it is taken.
  a_w1_load: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadTimerCtrlOne |=> accOut == $past(srcRegs.timerCtrlRegOne))
    else $error("first timer control read wrong");
  a_w2_opcode: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == 10'b1001001100
    |=> accOut == $past(srcRegs.timerCtrlRegTwo) && result.srcSel == 6'h02)
    else $error("second timer control read wrong");
  a_w3_load: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadTimerCtrlThree
    |=> accOut == $past(srcRegs.timerCtrlRegThree))
    else $error("third timer control read wrong");
  a_w4_load: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadTimerCtrlFour
    |=> accOut == $past(srcRegs.timerCtrlRegFour))
    else $error("fourth timer control read wrong");
  a_x_copy: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadXPointer |=> accOut == $past(srcRegs.xPointer))
    else $error("X pointer read wrong");
  a_y_copy: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadYPointer |=> accOut == $past(srcRegs.yPointer))
    else $error("Y pointer read wrong");
  a_carry_kept: assert property (@(posedge clk) disable iff (rst)
    sel != ALT_SRC_NONE |=> $stable(carryFlag) && result.loaded && !result.skipNext)
    else $error("transfer disturbed carry or skip");
  a_idle_hold: assert property (@(posedge clk) disable iff (rst)
    !instrValid |=> $stable(accOut) && !result.loaded)
    else $error("accumulator changed without instruction");

  // The result word must name the source that was actually read, one-hot.
  a_w1_select: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadTimerCtrlOne
    |=> result.loaded && result.srcSel == ALT_SRC_W1)
    else $error("first timer control read selected wrong source");
  a_w3_select: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadTimerCtrlThree
    |=> result.loaded && result.srcSel == ALT_SRC_W3)
    else $error("third timer control read selected wrong source");
  a_w4_select: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadTimerCtrlFour
    |=> result.loaded && result.srcSel == ALT_SRC_W4)
    else $error("fourth timer control read selected wrong source");
  a_x_select: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadXPointer
    |=> result.loaded && result.srcSel == ALT_SRC_X)
    else $error("X pointer read selected wrong source");
  a_y_select: assert property (@(posedge clk) disable iff (rst)
    instrValid && instrWord == OpReadYPointer
    |=> result.loaded && result.srcSel == ALT_SRC_Y)
    else $error("Y pointer read selected wrong source");

  // Only the exact printed word, and only while valid, may select the second register.
  a_w2_exact: assert property (@(posedge clk) disable iff (rst)
    !(instrValid && instrWord == 10'b1001001100) |=> result.srcSel != ALT_SRC_W2)
    else $error("second timer control register selected by another word");

  // A word that is no transfer must leave A alone and hand the carry through.
  a_refused_word: assert property (@(posedge clk) disable iff (rst)
    instrValid && sel == ALT_SRC_NONE
    |=> $stable(accOut) && !result.loaded && carryFlag == $past(carryIn))
    else $error("non-transfer word disturbed the accumulator");

  // The result stands for exactly one cycle: a transfer followed by a non-transfer clears it.
  a_result_pulse: assert property (@(posedge clk) disable iff (rst)
    sel != ALT_SRC_NONE ##1 sel == ALT_SRC_NONE |=> !result.loaded)
    else $error("transfer result stood longer than one cycle");

  // A may only move after a transfer or a reset; anything else would mean a second writer.
  // The reset term covers a one-cycle reset whose cleared value shows at the next edge.
  a_acc_cause: assert property (@(posedge clk) disable iff (rst)
    !$stable(accOut) |-> $past(sel != ALT_SRC_NONE) || $past(rst))
    else $error("accumulator moved without a transfer");

  // The loaded flag and the selector must always tell the same story.
  a_loaded_flag: assert property (@(posedge clk) disable iff (rst)
    result.loaded == (result.srcSel != SrcNone))
    else $error("loaded flag disagrees with source selector");
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the accumulator load transfer decoder.
`timescale 1ns/1ns
module tb_top;
  import alt_pkg::*;
  logic clk;
  logic rst;
  logic instrValid;
  logic [9:0] instrWord;
  alt_srcs_s srcRegs;
  logic carryIn;
  logic [3:0] accOut;
  logic carryFlag;
  alt_result_s result;
  alt_result_s expR;
  logic [3:0] expAcc;
  logic expCarry;
  logic [9:0] ops [6];
  int miscompares;
  int cmpCount;
  int seed;
  alt_load_transfers i_dut (.clk(clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .srcRegs(srcRegs), .carryIn(carryIn), .accOut(accOut),
    .carryFlag(carryFlag), .result(result));
  // Free-running clock at 125 MHz.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Expected result word; unknown opcodes and idle cycles give all zero.
  function automatic alt_result_s expRes(logic v, logic [9:0] w);
    alt_result_s r;
    r = '0;
    if (v)
    begin
      for (int k = 0; k < 6; k++)
        if (w == ops[k]) r.srcSel = 6'h01 << k;
      r.loaded = (r.srcSel != SrcNone);
    end
    return r;
  endfunction
  // Source nibble picked by a one-hot selector; the struct lists W1 first.
  function automatic logic [3:0] pick(alt_srcs_s s, logic [5:0] sel);
    logic [3:0] v;
    v = 4'h0;
    for (int k = 0; k < 6; k++)
      if (sel[k]) v = s[23-4*k -: 4];
    return v;
  endfunction
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    cmpCount++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // One instruction: drive at the falling edge, check one edge later.
  task automatic step(logic v, logic [9:0] w);
    @(negedge clk);
    instrValid = v;
    instrWord = w;
    srcRegs = alt_srcs_s'($random(seed));
    carryIn = 1'($random(seed));
    expR = expRes(v, w);
    if (expR.loaded) expAcc = pick(srcRegs, expR.srcSel);
    else expCarry = carryIn;
    @(posedge clk);
    #1;
    chk("acc", {4'h0, expAcc}, {4'h0, accOut});
    chk("carry", {7'h0, expCarry}, {7'h0, carryFlag});
    chk("result", expR, result);
  endtask
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Reset, corner cases back to back, then random traffic.
  initial
  begin
    seed = 32'hb3d2ef85;
    ops = '{OpReadTimerCtrlOneDflt, OpReadTimerCtrlTwo, OpReadTimerCtrlThreeDflt,
      OpReadTimerCtrlFourDflt, OpReadXPointerDflt, OpReadYPointerDflt};
    rst = 1'b1;
    instrValid = 1'b0;
    instrWord = 10'h000;
    srcRegs = '0;
    carryIn = 1'b1;
    miscompares = 0;
    cmpCount = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    #1;
    expAcc = AccReset;
    chk("rstAcc", 8'h00, {4'h0, accOut});
    chk("rstCarry", 8'h00, {7'h0, carryFlag});
    chk("rstResult", 8'h00, result);
    // The idle edge before the first step hands carryIn to the carry flag.
    expCarry = carryIn;
    step(1'b1, ops[0]);
    step(1'b1, 10'h24c);
    step(1'b1, ops[2]);
    step(1'b1, ops[3]);
    step(1'b1, ops[4]);
    step(1'b1, ops[5]);
    step(1'b0, 10'h24c);
    step(1'b1, 10'h24d);
    // Half of the random words are transfers, so back-to-back runs are frequent.
    repeat (400)
      if ($random(seed) & 1) step(1'b1, ops[($unsigned($random(seed))) % 6]);
      else step(1'($random(seed)), 10'($random(seed)));
    printVerdict();
  end
endmodule
